/* hdl/tpcp_defines.vh */
// Register map, field positions, reset values and timing counts of the PWM block
`ifndef TPCP_DEFINES_VH
`define TPCP_DEFINES_VH

// Register addresses on the data memory port
`define TPCP_A_PERIOD 4'h0
`define TPCP_A_DEAD 4'h1
`define TPCP_A_MINPW 4'h2
`define TPCP_A_GATE 4'h3
`define TPCP_A_DUTYA 4'h4
`define TPCP_A_DUTYB 4'h5
`define TPCP_A_DUTYC 4'h6
`define TPCP_A_SEG 4'h7
`define TPCP_A_STATUS 4'h8

// Output segment control fields
`define TPCP_SEG_XA 8
`define TPCP_SEG_XB 7
`define TPCP_SEG_XC 6
`define TPCP_SEG_DIS_CT 0
`define TPCP_SEG_DIS_CB 1
`define TPCP_SEG_DIS_BT 2
`define TPCP_SEG_DIS_BB 3
`define TPCP_SEG_DIS_AT 4
`define TPCP_SEG_DIS_AB 5

// Gate chop control fields
`define TPCP_GATE_DIV_MSB 5
`define TPCP_GATE_CHOP_TOP 8
`define TPCP_GATE_CHOP_BOT 9

// System status fields
`define TPCP_STAT_TRIP 0
`define TPCP_STAT_POL 2

// Reset values
`define TPCP_RST_PERIOD 12'h000
`define TPCP_RST_SEG 9'h000
`define TPCP_RST_GATE 10'h000
`define TPCP_RST_WORD 12'h000

// Timing: clock period and width of the cycle start pulse
`define TPCP_CLK_NS 10
`define TPCP_SYNC_NS 2000
`define TPCP_SYNC_CYC ((`TPCP_SYNC_NS + `TPCP_CLK_NS - 1) / `TPCP_CLK_NS)

`endif

/* hdl/tpcp_chop.v */
// Gate drive chopping carrier divider
`timescale 1ns/1ps
module tpcp_chop (
	// Clock and reset
	input wire clock,
	input wire rst,
	// Divider setting
	input wire [5:0] div,
	// Carrier out
	output reg carrier_r
);
	reg [5:0] cnt_r;

	// Toggle every div+1 clocks, so the carrier runs at clock / (2 * (div + 1))
	always @(posedge clock) begin
		if (rst) begin
			cnt_r <= 6'h00;
			carrier_r <= 1'b0;
		end else if (cnt_r >= div) begin
			cnt_r <= 6'h00;
			carrier_r <= ~carrier_r;
		end else begin
			cnt_r <= cnt_r + 6'h01;
		end
	end
endmodule // tpcp_chop

/* hdl/tpcp_top.v */
// Three-phase center-based PWM generator with output control and gate drive
`timescale 1ns/1ps
`include "tpcp_defines.vh"
module tpcp_top #(
	parameter SYNC_CYC = `TPCP_SYNC_CYC
) (
	// Clock and reset
	input wire clock,
	input wire rst,
	// Data memory register port
	input wire [3:0] dm_addr,
	input wire dm_wr,
	input wire [15:0] dm_wdata,
	output reg [15:0] dm_rdata_r,
	// Control pins
	input wire fault_shutdown_in,
	input wire output_polarity_in,
	// Inverter gate outputs
	output reg phase_a_top_out_r,
	output reg phase_a_bottom_out_r,
	output reg phase_b_top_out_r,
	output reg phase_b_bottom_out_r,
	output reg phase_c_top_out_r,
	output reg phase_c_bottom_out_r,
	// Cycle events
	output reg cycle_start_pulse_r,
	output reg sync_irq_r,
	output reg trip_irq_r
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	// Edge thresholds for one phase: {top threshold, bottom threshold}
	function [23:0] tpcp_edges;
		input [11:0] duty;
		input [11:0] per;
		input [11:0] dead;
		input [11:0] minpw;
		reg [12:0] hi;
		reg [12:0] lo;
		reg [12:0] half;
		reg [12:0] thh;
		begin
			// Deadtime comes off the top on time and off the bottom on time
			hi = (duty > dead) ? ({1'b0, duty} - {1'b0, dead}) : 13'h0000;
			hi = (hi > {1'b0, per}) ? {1'b0, per} : hi;
			lo = ({1'b0, per} > ({1'b0, duty} + {1'b0, dead})) ?
				({1'b0, per} - {1'b0, duty} - {1'b0, dead}) : 13'h0000;
			// Narrow pulses are removed and the pair saturated
			if (hi < {1'b0, minpw}) begin
				hi = 13'h0000;
				lo = {1'b0, per};
			end else if (lo < {1'b0, minpw}) begin
				hi = {1'b0, per};
				lo = 13'h0000;
			end
			half = {1'b0, per} >> 1;
			thh = half - (hi >> 1);
			tpcp_edges = {thh[11:0], lo[12:1]};
		end
	endfunction

	// Configuration and input registers
	reg [11:0] period_r;
	reg [11:0] dead_r;
	reg [11:0] minpw_r;
	reg [9:0] gate_r;
	reg [8:0] seg_r;
	reg [11:0] duty_a_r;
	reg [11:0] duty_b_r;
	reg [11:0] duty_c_r;
	reg [2:0] wr_seen_r;
	// Complete duty set waiting for the next cycle start
	reg [11:0] pend_a_r;
	reg [11:0] pend_b_r;
	reg [11:0] pend_c_r;
	// Per-cycle working copies
	reg [11:0] half_r;
	reg [8:0] seg_act_r;
	reg [23:0] edge_a_r;
	reg [23:0] edge_b_r;
	reg [23:0] edge_c_r;
	// Up/down counter and state
	reg [1:0] state_r;
	reg [11:0] cnt_r;
	reg up_r;
	reg [11:0] sync_cnt_r;
	// Pin synchronisers
	reg trip_s1_r;
	reg trip_s2_r;
	reg trip_d_r;
	reg pol_s1_r;
	reg pol_s2_r;

	wire carrier;
	wire tripped;
	wire trip_fall;
	wire period_ok;
	wire cyc_start;
	wire [2:0] wr_seen_nxt;
	reg [2:0] hi_t;
	reg [2:0] lo_t;
	reg [5:0] drive;
	reg [5:0] pin_nxt;
	reg [15:0] rdata_nxt;
	integer i;

	tpcp_chop u_chop (
		.clock(clock),
		.rst(rst),
		.div(gate_r[`TPCP_GATE_DIV_MSB:0]),
		.carrier_r(carrier)
	);

	// Trip and polarity pins pass two flops before use; trip interrupt on the synced fall
	always @(posedge clock) begin
		if (rst) begin
			trip_s1_r <= 1'b1;
			trip_s2_r <= 1'b1;
			trip_d_r <= 1'b1;
			pol_s1_r <= 1'b0;
			pol_s2_r <= 1'b0;
			trip_irq_r <= 1'b0;
		end else begin
			trip_s1_r <= fault_shutdown_in;
			trip_s2_r <= trip_s1_r;
			trip_d_r <= trip_s2_r;
			pol_s1_r <= output_polarity_in;
			pol_s2_r <= pol_s1_r;
			trip_irq_r <= trip_fall;
		end
	end

	assign tripped = ~trip_s2_r;
	assign trip_fall = trip_d_r & ~trip_s2_r;
	// Below two clocks the up/down count has no room to turn
	assign period_ok = (period_r > 12'h001);
	assign cyc_start = (state_r == ST_IDLE) ? (period_ok & ~tripped) :
		(~up_r & (cnt_r == 12'h000));

	// Duty write tracking; a write in the transfer cycle is lost, not kept for the next set
	assign wr_seen_nxt = wr_seen_r | {dm_wr & (dm_addr == `TPCP_A_DUTYC),
		dm_wr & (dm_addr == `TPCP_A_DUTYB), dm_wr & (dm_addr == `TPCP_A_DUTYA)};

	// Register writes
	always @(posedge clock) begin
		if (rst) begin
			period_r <= `TPCP_RST_PERIOD;
			dead_r <= `TPCP_RST_WORD;
			minpw_r <= `TPCP_RST_WORD;
			gate_r <= `TPCP_RST_GATE;
			seg_r <= `TPCP_RST_SEG;
			duty_a_r <= `TPCP_RST_WORD;
			duty_b_r <= `TPCP_RST_WORD;
			duty_c_r <= `TPCP_RST_WORD;
			dm_rdata_r <= 16'h0000;
		end else begin
			dm_rdata_r <= rdata_nxt; // Read data one cycle after the address
			if (dm_wr) begin
				case (dm_addr)
				`TPCP_A_PERIOD: period_r <= dm_wdata[11:0];
				`TPCP_A_DEAD: dead_r <= dm_wdata[11:0];
				`TPCP_A_MINPW: minpw_r <= dm_wdata[11:0];
				`TPCP_A_GATE: gate_r <= {dm_wdata[9:8], 2'b00, dm_wdata[5:0]};
				`TPCP_A_DUTYA: duty_a_r <= dm_wdata[11:0];
				`TPCP_A_DUTYB: duty_b_r <= dm_wdata[11:0];
				`TPCP_A_DUTYC: duty_c_r <= dm_wdata[11:0];
				`TPCP_A_SEG: seg_r <= dm_wdata[8:0];
				default: ;
				endcase
			end
			// A trip clears only the period register here: the period must be rewritten
			if (tripped) begin
				period_r <= `TPCP_RST_PERIOD;
			end
		end
	end

	// Hand over a duty set only once all three phases have been written
	always @(posedge clock) begin
		if (rst | tripped) begin
			wr_seen_r <= 3'b000;
			pend_a_r <= `TPCP_RST_WORD;
			pend_b_r <= `TPCP_RST_WORD;
			pend_c_r <= `TPCP_RST_WORD;
		end else if (&wr_seen_r) begin
			pend_a_r <= duty_a_r;
			pend_b_r <= duty_b_r;
			pend_c_r <= duty_c_r;
			wr_seen_r <= wr_seen_nxt & ~wr_seen_r;
		end else begin
			wr_seen_r <= wr_seen_nxt;
		end
	end

	// Cycle sequencer: count up to half the period minus one, then back down
	always @(posedge clock) begin
		if (rst | tripped) begin
			state_r <= ST_IDLE;
			cnt_r <= 12'h000;
			up_r <= 1'b1;
		end else begin
			case (state_r)
			ST_IDLE: begin
				cnt_r <= 12'h000;
				up_r <= 1'b1;
				if (cyc_start) begin
					state_r <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (up_r) begin
					if (cnt_r >= half_r - 12'h001) begin
						up_r <= 1'b0;
					end else begin
						cnt_r <= cnt_r + 12'h001;
					end
				end else if (cnt_r == 12'h000) begin
					up_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 12'h001;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// Per-cycle values are latched at the cycle start only
	always @(posedge clock) begin
		if (rst | tripped) begin
			half_r <= 12'h000;
			seg_act_r <= `TPCP_RST_SEG;
			edge_a_r <= 24'h000000;
			edge_b_r <= 24'h000000;
			edge_c_r <= 24'h000000;
		end else if (cyc_start) begin
			half_r <= period_r >> 1;
			seg_act_r <= seg_r;
			edge_a_r <= tpcp_edges(pend_a_r, period_r, dead_r, minpw_r);
			edge_b_r <= tpcp_edges(pend_b_r, period_r, dead_r, minpw_r);
			edge_c_r <= tpcp_edges(pend_c_r, period_r, dead_r, minpw_r);
		end
	end

	// Timing, output control and gate drive, ordered A top, A bottom, B, C
	always @* begin
		hi_t = 3'b000;
		lo_t = 3'b000;
		if (state_r == ST_RUN) begin
			hi_t[0] = (cnt_r >= edge_a_r[23:12]);
			hi_t[1] = (cnt_r >= edge_b_r[23:12]);
			hi_t[2] = (cnt_r >= edge_c_r[23:12]);
			lo_t[0] = (cnt_r < edge_a_r[11:0]) & ~hi_t[0];
			lo_t[1] = (cnt_r < edge_b_r[11:0]) & ~hi_t[1];
			lo_t[2] = (cnt_r < edge_c_r[11:0]) & ~hi_t[2];
		end
		// Crossover swaps which timing signal feeds each pin
		drive[0] = seg_act_r[`TPCP_SEG_XA] ? lo_t[0] : hi_t[0];
		drive[1] = seg_act_r[`TPCP_SEG_XA] ? hi_t[0] : lo_t[0];
		drive[2] = seg_act_r[`TPCP_SEG_XB] ? lo_t[1] : hi_t[1];
		drive[3] = seg_act_r[`TPCP_SEG_XB] ? hi_t[1] : lo_t[1];
		drive[4] = seg_act_r[`TPCP_SEG_XC] ? lo_t[2] : hi_t[2];
		drive[5] = seg_act_r[`TPCP_SEG_XC] ? hi_t[2] : lo_t[2];
		// Disable bits hold a pin off regardless of duty
		drive[0] = drive[0] & ~seg_act_r[`TPCP_SEG_DIS_AT];
		drive[1] = drive[1] & ~seg_act_r[`TPCP_SEG_DIS_AB];
		drive[2] = drive[2] & ~seg_act_r[`TPCP_SEG_DIS_BT];
		drive[3] = drive[3] & ~seg_act_r[`TPCP_SEG_DIS_BB];
		drive[4] = drive[4] & ~seg_act_r[`TPCP_SEG_DIS_CT];
		drive[5] = drive[5] & ~seg_act_r[`TPCP_SEG_DIS_CB];
		// Chop the on state, then apply pin polarity; even index is a top pin
		for (i = 0; i < 6; i = i + 1) begin
			if (i % 2 == 0) begin
				drive[i] = drive[i] & (carrier | ~gate_r[`TPCP_GATE_CHOP_TOP]);
			end else begin
				drive[i] = drive[i] & (carrier | ~gate_r[`TPCP_GATE_CHOP_BOT]);
			end
			pin_nxt[i] = pol_s2_r ? drive[i] : ~drive[i];
		end
	end

	// Output pins; off level follows the polarity pin once out of reset
	always @(posedge clock) begin
		if (rst) begin
			phase_a_top_out_r <= 1'b0;
			phase_a_bottom_out_r <= 1'b0;
			phase_b_top_out_r <= 1'b0;
			phase_b_bottom_out_r <= 1'b0;
			phase_c_top_out_r <= 1'b0;
			phase_c_bottom_out_r <= 1'b0;
		end else begin
			phase_a_top_out_r <= pin_nxt[0];
			phase_a_bottom_out_r <= pin_nxt[1];
			phase_b_top_out_r <= pin_nxt[2];
			phase_b_bottom_out_r <= pin_nxt[3];
			phase_c_top_out_r <= pin_nxt[4];
			phase_c_bottom_out_r <= pin_nxt[5];
		end
	end

	// Sync pulse stretched for the ADC ramp reset; restarts at every cycle start
	always @(posedge clock) begin
		if (rst | tripped) begin
			sync_cnt_r <= 12'h000;
			cycle_start_pulse_r <= 1'b0;
			sync_irq_r <= 1'b0;
		end else begin
			sync_irq_r <= cyc_start;
			if (cyc_start) begin
				sync_cnt_r <= SYNC_CYC[11:0] - 12'h001;
				cycle_start_pulse_r <= 1'b1;
			end else if (sync_cnt_r != 12'h000) begin
				sync_cnt_r <= sync_cnt_r - 12'h001;
			end else begin
				cycle_start_pulse_r <= 1'b0;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always @* begin
		rdata_nxt = 16'h0000;
		case (dm_addr)
		`TPCP_A_PERIOD: rdata_nxt = {4'h0, period_r};
		`TPCP_A_DEAD: rdata_nxt = {4'h0, dead_r};
		`TPCP_A_MINPW: rdata_nxt = {4'h0, minpw_r};
		`TPCP_A_GATE: rdata_nxt = {6'h00, gate_r};
		`TPCP_A_DUTYA: rdata_nxt = {4'h0, duty_a_r};
		`TPCP_A_DUTYB: rdata_nxt = {4'h0, duty_b_r};
		`TPCP_A_DUTYC: rdata_nxt = {4'h0, duty_c_r};
		`TPCP_A_SEG: rdata_nxt = {7'h00, seg_r};
		`TPCP_A_STATUS: begin
			rdata_nxt[`TPCP_STAT_TRIP] = trip_s2_r;
			rdata_nxt[`TPCP_STAT_POL] = pol_s2_r;
		end
		default: rdata_nxt = 16'h0000;
		endcase
	end
endmodule // tpcp_top

/* bench/tpcp_top_chk.sv */
// Port-level assertions for the three-phase PWM block
`timescale 1ns/1ps
`include "tpcp_defines.vh"
module tpcp_top_chk #(
	parameter SYNC_CYC = `TPCP_SYNC_CYC
) (
	// Clock, reset, register port
	input wire clock,
	input wire rst,
	input wire [3:0] dm_addr,
	input wire dm_wr,
	input wire [15:0] dm_wdata,
	input wire [15:0] dm_rdata_r,
	// Pins and events
	input wire fault_shutdown_in,
	input wire output_polarity_in,
	input wire phase_a_top_out_r,
	input wire phase_a_bottom_out_r,
	input wire phase_b_top_out_r,
	input wire phase_b_bottom_out_r,
	input wire phase_c_top_out_r,
	input wire phase_c_bottom_out_r,
	input wire cycle_start_pulse_r,
	input wire sync_irq_r,
	input wire trip_irq_r
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	reg [15:0] run_r;
	wire [5:0] pins = {phase_c_bottom_out_r, phase_c_top_out_r, phase_b_bottom_out_r,
		phase_b_top_out_r, phase_a_bottom_out_r, phase_a_top_out_r};

	// Clocks since the last cycle start, saturating so long idles never wrap
	always @(posedge clock) begin
		if (rst) run_r <= 16'h0000;
		else if (sync_irq_r) run_r <= 16'h0001;
		else if (run_r != 16'hffff) run_r <= run_r + 16'h0001;
	end

	a_no_shoot_thru: assert property (output_polarity_in [*5] |->
		!(pins[0] && pins[1]) && !(pins[2] && pins[3]) && !(pins[4] && pins[5]))
		else $error("pair driven on together");
	a_sync_width: assert property (cycle_start_pulse_r && !sync_irq_r |->
		run_r != 16'h0000 && run_r < SYNC_CYC) else $error("sync pulse width wrong");
	a_irq_in_pulse: assert property (sync_irq_r |-> cycle_start_pulse_r)
		else $error("interrupt outside sync pulse");
	a_irq_single: assert property (sync_irq_r |=> !sync_irq_r) else $error("irq too long");
	a_trip_irq_soon: assert property ($fell(fault_shutdown_in) |-> ##[1:4] trip_irq_r)
		else $error("no trip interrupt");
	a_trip_off_high: assert property ((!fault_shutdown_in && output_polarity_in) [*6] |->
		pins == 6'h00) else $error("pins on while tripped");
	a_trip_off_low: assert property ((!fault_shutdown_in && !output_polarity_in) [*6] |->
		pins == 6'h3f) else $error("low polarity off level wrong");
	a_status_trip: assert property (($stable(fault_shutdown_in) [*4] ##0
		dm_addr == `TPCP_A_STATUS) |=> dm_rdata_r[`TPCP_STAT_TRIP] == $past(fault_shutdown_in))
		else $error("status trip bit wrong");
	property period_back;
		logic [11:0] v;
		(dm_wr && dm_addr == `TPCP_A_PERIOD && fault_shutdown_in, v = dm_wdata[11:0]) ##1
		(!dm_wr && dm_addr == `TPCP_A_PERIOD && fault_shutdown_in) |=> dm_rdata_r == {4'h0, v};
	endproperty
	a_period_readback: assert property (period_back) else $error("period readback wrong");
	c_sync: cover property (sync_irq_r);
	c_trip: cover property (trip_irq_r);
	c_pol_low: cover property (!output_polarity_in && phase_a_top_out_r == 1'b0);
endmodule // tpcp_top_chk

bind tpcp_top tpcp_top_chk #(.SYNC_CYC(SYNC_CYC)) i_tpcp_top_chk (.clock(clock), .rst(rst),
	.dm_addr(dm_addr), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata_r(dm_rdata_r),
	.fault_shutdown_in(fault_shutdown_in), .output_polarity_in(output_polarity_in),
	.phase_a_top_out_r(phase_a_top_out_r), .phase_a_bottom_out_r(phase_a_bottom_out_r),
	.phase_b_top_out_r(phase_b_top_out_r), .phase_b_bottom_out_r(phase_b_bottom_out_r),
	.phase_c_top_out_r(phase_c_top_out_r), .phase_c_bottom_out_r(phase_c_bottom_out_r),
	.cycle_start_pulse_r(cycle_start_pulse_r), .sync_irq_r(sync_irq_r), .trip_irq_r(trip_irq_r));

/* bench/tpcp_inverter_model.sv */
// Inverter gate drive side: decodes the pins and counts shorted legs
`timescale 1ns/1ps
module tpcp_inverter_model (
	// Clock
	input wire clock,
	// Hardwired polarity and gate pins
	input wire pol,
	input wire [5:0] pins,
	// Shorted leg count
	output integer shoot_cnt
);
	reg [5:0] hist_r;
	wire [5:0] on_w = pol ? pins : ~pins;
	initial shoot_cnt = 0;
	initial hist_r = 6'h00;
	// Skip the few clocks after a polarity change, the pins lag the strap
	always @(posedge clock) begin
		hist_r <= {hist_r[4:0], pol};
		if (hist_r == {6{pol}} && ((on_w[0] & on_w[1]) | (on_w[2] & on_w[3]) | (on_w[4] & on_w[5])))
			shoot_cnt <= shoot_cnt + 1;
	end
endmodule // tpcp_inverter_model

/* bench/three_phase_center_pwm_tb_top.sv */
// Self-checking bench for the three-phase PWM block
`timescale 1ns/1ps
`include "tpcp_defines.vh"
module three_phase_center_pwm_tb_top;
	localparam int PER = 20;
	localparam int DEAD = 2;
	localparam int SYNC = 4;
	logic clock, rst, dm_wr, trip_in, pol_in;
	logic [3:0] dm_addr;
	logic [15:0] dm_wdata;
	logic [1:0] chop = 2'b00;
	wire [15:0] rdata;
	wire [5:0] pins;
	wire sync_p, sync_irq, trip_irq;
	integer shoot_cnt;
	int num_errors = 0, tests_run = 0, cyc = 0, n = 0, c = 0;
	int hi_c[3], lo_c[3], seen[6];
	logic [8:0] segs[7] = '{9'h100, 9'h080, 9'h040, 9'h03f, 9'h0a7, 9'h008, 9'h010};

	tpcp_top #(.SYNC_CYC(SYNC)) i_tpcp_top (.clock(clock), .rst(rst), .dm_addr(dm_addr),
		.dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata_r(rdata), .fault_shutdown_in(trip_in),
		.output_polarity_in(pol_in), .phase_a_top_out_r(pins[0]), .phase_a_bottom_out_r(pins[1]),
		.phase_b_top_out_r(pins[2]), .phase_b_bottom_out_r(pins[3]), .phase_c_top_out_r(pins[4]),
		.phase_c_bottom_out_r(pins[5]), .cycle_start_pulse_r(sync_p), .sync_irq_r(sync_irq),
		.trip_irq_r(trip_irq));
	tpcp_inverter_model i_inv (.clock(clock), .pol(pol_in), .pins(pins), .shoot_cnt(shoot_cnt));

	// Clock and hang guard
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task wrap_up;
		$display("Checks run %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task chk_cnt(input string what, input int e, input int g);
		tests_run++;
		if (g != e) begin
			num_errors++;
			$display("Error %s expected %0d seen %0d", what, e, g);
		end
	endtask

	// Register port: one strobed edge per write, data one edge after the address
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(negedge clock);
		dm_addr = a;
		dm_wdata = d;
		dm_wr = 1'b1;
		@(negedge clock);
		dm_wr = 1'b0;
	endtask
	task rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(negedge clock);
		dm_addr = a;
		@(negedge clock);
		chk_word("register read", e, rdata);
	endtask

	// Bounded wait for the next cycle start; n is the clocks waited
	task wait_sync;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (sync_irq !== 1'b1 && n < 200);
	endtask

	function automatic int exp_on(input logic [8:0] seg, input int i);
		int p;
		int b;
		int v;
		p = i / 2;
		b = i % 2;
		v = (seg[8 - p] ^ b[0]) ? lo_c[p] : hi_c[p];
		if (seg[4 - 2 * p + b]) v = 0;
		if (chop[b]) v = v / 2;
		return v;
	endfunction

	// Writes a full duty set; expected on-clocks per cycle follow the edge equations
	task load(input int da, input int db, input int dc, input int mp);
		int d[3];
		int hi;
		int lo;
		d = '{da, db, dc};
		wr(`TPCP_A_MINPW, 16'(mp));
		for (int p = 0; p < 3; p++) begin
			wr(`TPCP_A_DUTYA + 4'(p), 16'(d[p]));
			hi = d[p] - DEAD;
			if (hi < 0) hi = 0;
			lo = PER - d[p] - DEAD;
			if (lo < 0) lo = 0;
			if (hi < mp) begin
				hi = 0;
				lo = PER;
			end else if (lo < mp) begin
				hi = PER;
				lo = 0;
			end
			hi_c[p] = hi / 2 * 2;
			lo_c[p] = lo / 2 * 2;
		end
	endtask

	// Settle two cycles, then count active clocks of each pin over one whole cycle
	task meas_chk(input logic [8:0] seg, input logic lvl);
		wait_sync();
		wait_sync();
		seen = '{default: 0};
		repeat (PER) begin
			@(negedge clock);
			for (int i = 0; i < 6; i++) seen[i] += (pins[i] === lvl);
		end
		for (int i = 0; i < 6; i++) chk_cnt("pin on clocks", exp_on(seg, i), seen[i]);
	endtask

	task t_reset_idle;
		rd_chk(`TPCP_A_SEG, 16'h0000);
		rd_chk(`TPCP_A_PERIOD, 16'h0000);
		rd_chk(4'h9, 16'h0000);
		rd_chk(`TPCP_A_STATUS, 16'h0005);
		wait_sync();
		chk_cnt("idle before period", 200, n);
	endtask

	task t_wave;
		wr(`TPCP_A_PERIOD, 16'(PER));
		wr(`TPCP_A_DEAD, 16'(DEAD));
		wr(`TPCP_A_GATE, 16'h0000);
		load(10, 12, 8, 0);
		meas_chk(9'h000, 1'b1);
		wait_sync();
		chk_cnt("cycle length", PER, n);
		c = 0;
		repeat (PER) begin
			c += (sync_p === 1'b1);
			@(negedge clock);
		end
		chk_cnt("sync pulse clocks", SYNC, c);
		wr(`TPCP_A_DUTYA, 16'h000e);
		meas_chk(9'h000, 1'b1);
		load(14, 12, 8, 0);
		meas_chk(9'h000, 1'b1);
	endtask

	task t_segments;
		foreach (segs[k]) begin
			wr(`TPCP_A_SEG, {7'h00, segs[k]});
			meas_chk(segs[k], 1'b1);
		end
		wr(`TPCP_A_SEG, 16'h0000);
		wait_sync();
		wr(`TPCP_A_SEG, 16'h0010);
		c = 0;
		while (sync_irq !== 1'b1 && c < 100) begin
			@(negedge clock);
			c += (pins[0] === 1'b1);
		end
		chk_cnt("top before next start", hi_c[0], c);
		wr(`TPCP_A_SEG, 16'h0000);
	endtask

	task t_chop_pol;
		load(10, 14, 6, 0);
		chop = 2'b01;
		wr(`TPCP_A_GATE, 16'h0101);
		meas_chk(9'h000, 1'b1);
		chop = 2'b10;
		wr(`TPCP_A_GATE, 16'h0201);
		meas_chk(9'h000, 1'b1);
		chop = 2'b00;
		wr(`TPCP_A_GATE, 16'h0000);
		@(negedge clock);
		pol_in = 1'b0;
		meas_chk(9'h000, 1'b0);
		@(negedge clock);
		pol_in = 1'b1;
		load(10, 14, 6, 9);
		meas_chk(9'h000, 1'b1);
	endtask

	task t_trip;
		@(negedge clock);
		trip_in = 1'b0;
		c = 0;
		repeat (6) begin
			@(negedge clock);
			c += (trip_irq === 1'b1);
		end
		chk_cnt("trip interrupts", 1, c);
		chk_word("tripped pins", 16'h0000, {10'h000, pins});
		rd_chk(`TPCP_A_STATUS, 16'h0004);
		rd_chk(`TPCP_A_PERIOD, 16'h0000);
		// Off level while tripped must follow the polarity pin
		pol_in = 1'b0;
		repeat (8) @(negedge clock);
		chk_word("tripped pins low polarity", 16'h003f, {10'h000, pins});
		pol_in = 1'b1;
		trip_in = 1'b1;
		repeat (4) @(negedge clock);
		rd_chk(`TPCP_A_STATUS, 16'h0005);
		wait_sync();
		chk_cnt("idle after trip", 200, n);
		wr(`TPCP_A_PERIOD, 16'(PER));
		load(10, 12, 8, 0);
		meas_chk(9'h000, 1'b1);
	endtask

	initial begin
		rst = 1'b1;
		dm_wr = 1'b0;
		dm_addr = 4'h0;
		dm_wdata = 16'h0000;
		trip_in = 1'b1;
		pol_in = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		t_reset_idle();
		t_wave();
		t_segments();
		t_chop_pol();
		t_trip();
		chk_cnt("shorted legs", 0, shoot_cnt);
		wrap_up();
	end
endmodule // three_phase_center_pwm_tb_top
